// ### hdl/bwd_board_ctrl.v
// Board watchdogs, panel button, boot flash fail-over and switch decode
`timescale 1ns/1ns
`include "bwd_board_defs.vh"
module bwd_board_ctrl #(
   parameter [31:0] PRESS_CYC = `BWD_PRESS_CYC,  // Button long-press count
   parameter [31:0] BOOT_WD_CYC = `BWD_BOOT_WD_CYC, // Boot watchdog period
   parameter [31:0] OS_WD_CYC   = `BWD_OS_WD_CYC,   // OS watchdog period
   parameter [31:0] HRST_CYC  = `BWD_HRST_CYC    // Reset pulse length
) (
   input  wire                   ref_clk,         // Block clock
   input  wire                   reset,           // Synchronous reset
   input  wire                   wdEnableSw,      // Watchdog enable switch
   input  wire                   consoleRearSw,   // Console routing switch
   input  wire [3:0]             rearDiffSw,      // Rear port line mode
   input  wire                   frontDiffSw,     // Front console line mode
   input  wire                   fabricPcieSw,    // Backplane fabric switch
   input  wire                   portBInvertSw,   // Port B opposite switch
   input  wire                   flashWpSw,       // Flash write protect
   input  wire [`BWD_GA_W-1:0]   geoAddrSw,       // Address switches, on=1
   input  wire                   endpointSw,      // Endpoint switch
   input  wire                   autoRoleSw,      // Manual role when on
   input  wire                   manualRoleSel,   // Non-controller when on
   input  wire                   bootAltSw,       // Boot flash strap
   input  wire                   panelButton_n,   // Panel button, low=pressed
   input  wire                   slotOneDetect,   // Auto role detect
   input  wire [`BWD_GA_W-1:0]   geoAddrIn,       // Address pin levels
   input  wire                   cmdWrite,        // Command write strobe
   input  wire [15:0]            cmdData,         // Command code
   input  wire                   procCs0_n,       // Processor boot select
   input  wire                   procCs1_n,       // Processor second select
   output reg                    consoleToRear_r, // Console to rear
   output reg  [`BWD_SER_W-1:0]  serialDiff_r,    // Line mode, bit 4 front
   output reg                    portAPcie_r,     // Port A fabric
   output reg                    portBPcie_r,     // Port B fabric
   output reg                    flashWp_r,       // Flash write protect
   output reg  [`BWD_GA_W-1:0]   geoAddrOut_r,    // Address pin drive level
   output reg  [`BWD_GA_W-1:0]   geoAddrOe_r,     // Address pin enable
   output reg  [`BWD_GA_W-1:0]   geoAddrSeen_r,   // Address pin state
   output reg                    fabricEndpoint_r,// Endpoint configuration
   output reg                    sysCtrlRole_r,   // System controller role
   output reg                    flash0Cs_n_r,    // Flash 0 chip select
   output reg                    flash1Cs_n_r,    // Flash 1 chip select
   output reg                    bootFromAlt_r,   // Flash 1 is boot device
   output reg                    abortIrq_r,      // Abort interrupt pulse
   output reg                    hardReset_r,     // Board hard reset
   output reg                    sysReset_r,      // Backplane reset
   output reg                    porRequest_r,    // Power-on reset request
   output reg                    bootWdActive_r,  // Boot watchdog running
   output reg                    osWdActive_r     // OS watchdog armed
);

   localparam SYNC_W = 30;

   localparam [1:0] ST_BOOT = 2'd0;
   localparam [1:0] ST_OS   = 2'd1;
   localparam [1:0] ST_IDLE = 2'd2;
   localparam [1:0] ST_RST  = 2'd3;

   function isCode;
      input [15:0] data;
      input [15:0] code;
      begin
         isCode = (data == code);
      end
   endfunction

   // Pin synchronisation
   wire [SYNC_W-1:0] pinRaw;
   wire [SYNC_W-1:0] pinSync;
   wire [SYNC_W-1:0] pinIdle;

   assign pinRaw = {wdEnableSw, consoleRearSw, rearDiffSw, frontDiffSw,
                    fabricPcieSw, portBInvertSw, flashWpSw, geoAddrSw,
                    endpointSw, autoRoleSw, manualRoleSel, bootAltSw,
                    panelButton_n, slotOneDetect, geoAddrIn,
                    procCs0_n, procCs1_n};
   // Active-low pins rest high through reset
   assign pinIdle = `BWD_PIN_IDLE;

   bwd_sync #(
      .WIDTH     (SYNC_W)
   ) u_bwd_sync (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .asyncIn   (pinRaw),
      .resetVal  (pinIdle),
      .syncOut_r (pinSync)
   );

   wire                 wdEn      = pinSync[29];
   wire                 consRear  = pinSync[28];
   wire [3:0]           rearDiff  = pinSync[27:24];
   wire                 frontDiff = pinSync[23];
   wire                 fabPcie   = pinSync[22];
   wire                 portBInv  = pinSync[21];
   wire                 wpSw      = pinSync[20];
   wire [`BWD_GA_W-1:0] gaSw      = pinSync[19:14];
   wire                 epSw      = pinSync[13];
   wire                 manRole   = pinSync[12];
   wire                 roleSel   = pinSync[11];
   wire                 altSw     = pinSync[10];
   wire                 btnPress  = ~pinSync[9];
   wire                 slotOne   = pinSync[8];
   wire [`BWD_GA_W-1:0] gaPins    = pinSync[7:2];
   wire                 cs0_n     = pinSync[1];
   wire                 cs1_n     = pinSync[0];

   // Static switch decode
   always @(posedge ref_clk) begin
      if (reset) begin
         consoleToRear_r  <= 1'b0;
         serialDiff_r     <= {`BWD_SER_W{1'b0}};
         portAPcie_r      <= 1'b0;
         portBPcie_r      <= 1'b0;
         flashWp_r        <= 1'b0;
         geoAddrOut_r     <= `BWD_GA_RST;
         geoAddrOe_r      <= `BWD_GA_RST;
         geoAddrSeen_r    <= `BWD_GA_RST;
         fabricEndpoint_r <= 1'b0;
         sysCtrlRole_r    <= 1'b0;
      end else begin
         consoleToRear_r  <= consRear;
         serialDiff_r     <= {frontDiff, rearDiff};
         portAPcie_r      <= fabPcie;
         portBPcie_r      <= fabPcie ^ portBInv;
         flashWp_r        <= wpSw;
         // Switch on pulls the shared line low
         geoAddrOut_r     <= `BWD_GA_RST;
         geoAddrOe_r      <= gaSw;
         geoAddrSeen_r    <= gaPins;
         fabricEndpoint_r <= epSw;
         sysCtrlRole_r    <= manRole ? ~roleSel : slotOne;
      end
   end

   // Boot strap capture after the synchroniser settles
   reg [1:0] settle_r;
   reg       strapDone_r;
   reg       strapAlt_r;
   reg       failedOver_r;
   wire      useAlt = strapAlt_r | failedOver_r;

   always @(posedge ref_clk) begin
      if (reset) begin
         settle_r    <= 2'd0;
         strapDone_r <= 1'b0;
         strapAlt_r  <= 1'b0;
      end else if (!strapDone_r) begin
         settle_r <= settle_r + 2'd1;
         if (settle_r == `BWD_SETTLE_CYC) begin
            strapDone_r <= 1'b1;
            strapAlt_r  <= altSw;
         end
      end
   end

   // Chip select steering
   always @(posedge ref_clk) begin
      if (reset) begin
         flash0Cs_n_r  <= 1'b1;
         flash1Cs_n_r  <= 1'b1;
         bootFromAlt_r <= 1'b0;
      end else if (!strapDone_r) begin
         flash0Cs_n_r  <= 1'b1;
         flash1Cs_n_r  <= 1'b1;
      end else begin
         bootFromAlt_r <= useAlt;
         flash0Cs_n_r  <= useAlt ? cs1_n : cs0_n;
         flash1Cs_n_r  <= useAlt ? cs0_n : cs1_n;
      end
   end

   // Panel button timing
   reg [31:0] pressCnt_r;
   reg        pressLong_r;
   reg        btnPrev_r;
   reg        btnReset_r;

   always @(posedge ref_clk) begin
      if (reset) begin
         pressCnt_r  <= `BWD_CNT_RST;
         pressLong_r <= 1'b0;
         btnPrev_r   <= 1'b0;
         btnReset_r  <= 1'b0;
         abortIrq_r  <= 1'b0;
      end else begin
         btnPrev_r  <= btnPress;
         btnReset_r <= 1'b0;
         abortIrq_r <= 1'b0;
         if (btnPress) begin
            if (!pressLong_r) begin
               if (pressCnt_r == PRESS_CYC) begin
                  pressLong_r <= 1'b1;
                  btnReset_r  <= 1'b1;
               end else begin
                  pressCnt_r <= pressCnt_r + 32'd1;
               end
            end
         end else begin
            pressCnt_r  <= `BWD_CNT_RST;
            pressLong_r <= 1'b0;
            if (btnPrev_r && !pressLong_r) begin
               abortIrq_r <= 1'b1;
            end
         end
      end
   end

   // Watchdog sequencer
   reg [1:0]  state_r;
   reg [1:0]  state_nxt;
   reg [31:0] wdCnt_r;
   reg [31:0] wdCnt_nxt;
   reg        rstPor_r;
   reg        rstPor_nxt;
   reg        failedOver_nxt;

   // Of host writes, only the two exact codes move the sequencer
   wire cmdBoot = cmdWrite && isCode(cmdData, `BWD_CODE_BOOT);
   wire cmdOs   = cmdWrite && isCode(cmdData, `BWD_CODE_OS);

   always @* begin
      state_nxt      = state_r;
      wdCnt_nxt      = wdCnt_r;
      rstPor_nxt     = rstPor_r;
      failedOver_nxt = failedOver_r;
      case (state_r)
         ST_BOOT: begin
            if (!wdEn) begin
               wdCnt_nxt = `BWD_CNT_RST;
            end else begin
               wdCnt_nxt = wdCnt_r + 32'd1;
            end
            if (cmdBoot) begin
               state_nxt = ST_OS;
               wdCnt_nxt = `BWD_CNT_RST;
            end else if (wdEn && wdCnt_r == BOOT_WD_CYC - 32'd1) begin
               state_nxt      = ST_RST;
               rstPor_nxt     = 1'b1;
               failedOver_nxt = 1'b1;
               wdCnt_nxt      = `BWD_CNT_RST;
            end
         end
         ST_OS: begin
            if (!wdEn) begin
               wdCnt_nxt = `BWD_CNT_RST;
            end else begin
               wdCnt_nxt = wdCnt_r + 32'd1;
            end
            if (cmdOs) begin
               state_nxt = ST_IDLE;
               wdCnt_nxt = `BWD_CNT_RST;
            end else if (wdEn && wdCnt_r == OS_WD_CYC - 32'd1) begin
               state_nxt  = ST_RST;
               rstPor_nxt = 1'b0;
               wdCnt_nxt  = `BWD_CNT_RST;
            end
         end
         ST_IDLE: begin
            wdCnt_nxt = `BWD_CNT_RST;
         end
         ST_RST: begin
            if (wdCnt_r == HRST_CYC - 32'd1) begin
               // Board leaves reset, boot watchdog restarts
               state_nxt = ST_BOOT;
               wdCnt_nxt = `BWD_CNT_RST;
            end else begin
               wdCnt_nxt = wdCnt_r + 32'd1;
            end
         end
         default: begin
            state_nxt = ST_BOOT;
            wdCnt_nxt = `BWD_CNT_RST;
         end
      endcase
      // Long press overrides watchdog activity
      if (btnReset_r && state_r != ST_RST) begin
         state_nxt  = ST_RST;
         rstPor_nxt = 1'b0;
         wdCnt_nxt  = `BWD_CNT_RST;
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         state_r      <= ST_BOOT;
         wdCnt_r      <= `BWD_CNT_RST;
         rstPor_r     <= 1'b0;
         failedOver_r <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         wdCnt_r      <= wdCnt_nxt;
         rstPor_r     <= rstPor_nxt;
         failedOver_r <= failedOver_nxt;
      end
   end

   // Reset and status outputs
   always @(posedge ref_clk) begin
      if (reset) begin
         hardReset_r  <= 1'b0;
         sysReset_r   <= 1'b0;
         porRequest_r <= 1'b0;
         bootWdActive_r <= 1'b0;
         osWdActive_r   <= 1'b0;
      end else begin
         hardReset_r  <= (state_r == ST_RST) && !rstPor_r;
         sysReset_r   <= (state_r == ST_RST) && !rstPor_r
                         && sysCtrlRole_r;
         porRequest_r <= (state_r == ST_RST) && rstPor_r;
         bootWdActive_r <= (state_r == ST_BOOT) && wdEn;
         osWdActive_r   <= (state_r == ST_OS) && wdEn;
      end
   end

endmodule

// ### hdl/bwd_board_defs.vh
// Constants for the board watchdog, reset and boot control block
`ifndef BWD_BOARD_DEFS_VH
`define BWD_BOARD_DEFS_VH

// Clock rate
`define BWD_CLK_HZ        32'd20000000
`define BWD_CLK_KHZ       (`BWD_CLK_HZ / 32'd1000)

// Times in their own units
`define BWD_PRESS_S       32'd3
`define BWD_BOOT_WD_S     32'd8
`define BWD_OS_WD_S       32'd108
`define BWD_HRST_MS       32'd200

// Derived cycle counts
`define BWD_PRESS_CYC     (`BWD_PRESS_S * `BWD_CLK_HZ)
`define BWD_BOOT_WD_CYC   (`BWD_BOOT_WD_S * `BWD_CLK_HZ)
`define BWD_OS_WD_CYC     (`BWD_OS_WD_S * `BWD_CLK_HZ)
`define BWD_HRST_CYC      (`BWD_HRST_MS * `BWD_CLK_KHZ)

// Command codes written by the host
`define BWD_CODE_BOOT     16'heea1
`define BWD_CODE_OS       16'hbbc2

// Cycles after reset before the boot strap is caught
`define BWD_SETTLE_CYC    2'd3

// Geographic address field: bit 5 parity, bits 4:0 address
`define BWD_GAP_BIT       5
`define BWD_GA_W          6
`define BWD_SER_W         5

// Reset values
`define BWD_CNT_RST       32'h00000000
`define BWD_GA_RST        6'h00
// Synchroniser idle levels: button and both chip selects high
`define BWD_PIN_IDLE      30'h00000203

`endif

// ### hdl/bwd_sync.v
// Two-stage synchroniser for a bus of independent levels
`timescale 1ns/1ns
module bwd_sync #(
   parameter WIDTH = 1
) (
   input  wire             ref_clk,   // Block clock
   input  wire             reset,     // Synchronous reset, active high
   input  wire [WIDTH-1:0] asyncIn,   // Levels from pins
   input  wire [WIDTH-1:0] resetVal,  // Constant idle level per bit
   output reg  [WIDTH-1:0] syncOut_r  // Levels in the clock domain
);

   reg [WIDTH-1:0] stage1_r;

   // First stage is read only by the second
   always @(posedge ref_clk) begin
      if (reset) begin
         // Idle levels so no false edge follows reset
         stage1_r  <= resetVal;
         syncOut_r <= resetVal;
      end else begin
         stage1_r  <= asyncIn;
         syncOut_r <= stage1_r;
      end
   end

endmodule

// ### tb/bwd_host_model.sv
// Host side model that writes command codes into the block
`timescale 1ns/1ns
module bwd_host_model (
   input  wire        ref_clk,  // Block clock
   output reg         cmdWrite, // Command strobe
   output reg  [15:0] cmdData   // Command code
);
   initial begin
      cmdWrite = 1'b0;
      cmdData  = 16'h0000;
   end
   // One-cycle write; data scrambled once released
   task send(input [15:0] code);
      begin
         @(negedge ref_clk);
         cmdWrite = 1'b1;
         cmdData  = code;
         @(negedge ref_clk);
         cmdWrite = 1'b0;
         cmdData  = ~code;
      end
   endtask
endmodule

// ### tb/bwd_ctrl_assertions.sv
// Concurrent checks on the board control block ports
`timescale 1ns/1ns
`include "bwd_board_defs.vh"
module bwd_ctrl_chk #(
   parameter [31:0] HRST_CYC = 32'd10  // Reset pulse length
) (
   input  wire                 ref_clk,       // Clock
   input  wire                 reset,         // Reset
   input  wire                 fabricPcieSw,  // Switch
   input  wire                 portBInvertSw, // Switch
   input  wire [`BWD_GA_W-1:0] geoAddrSw,     // Switches
   input  wire                 autoRoleSw,    // Switch
   input  wire                 manualRoleSel, // Switch
   input  wire                 slotOneDetect, // Role detect
   input  wire                 panelButton_n, // Button
   input  wire                 cmdWrite,      // Strobe
   input  wire [15:0]          cmdData,       // Code
   input  wire                 procCs0_n,     // Select
   input  wire                 procCs1_n,     // Select
   input  wire                 portAPcie_r,   // Fabric
   input  wire                 portBPcie_r,   // Fabric
   input  wire [`BWD_GA_W-1:0] geoAddrOut_r,  // Drive level
   input  wire [`BWD_GA_W-1:0] geoAddrOe_r,   // Enable
   input  wire                 sysCtrlRole_r, // Role
   input  wire                 flash0Cs_n_r,  // Flash select
   input  wire                 bootFromAlt_r, // Boot device
   input  wire                 abortIrq_r,    // Abort
   input  wire                 hardReset_r,   // Hard reset
   input  wire                 sysReset_r,    // Backplane reset
   input  wire                 porRequest_r,  // Power-on request
   input  wire                 bootWdActive_r, // Boot watchdog
   input  wire                 osWdActive_r    // OS watchdog
);
   reg [3:0]  upCnt;
   reg [31:0] hrCnt;
   always @(posedge ref_clk) begin
      if (reset) begin
         upCnt <= 4'h0;
         hrCnt <= 32'h00000000;
      end else begin
         upCnt <= (upCnt == 4'hf) ? upCnt : upCnt + 4'h1;
         hrCnt <= hardReset_r ? hrCnt + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   fabric_sel_a: assert property (
      upCnt == 4'hf |-> portAPcie_r == $past(fabricPcieSw, 3)
         && (portAPcie_r ^ portBPcie_r) == $past(portBInvertSw, 3))
      else $error("fabric select mismatch");
   geo_invert_a: assert property (
      upCnt == 4'hf |-> geoAddrOut_r == 6'h00 && geoAddrOe_r == $past(geoAddrSw, 3))
      else $error("address drive mismatch");
   role_sel_a: assert property (
      upCnt == 4'hf |-> sysCtrlRole_r == ($past(autoRoleSw, 3) ?
         !$past(manualRoleSel, 3) : $past(slotOneDetect, 3)))
      else $error("role mismatch");
   cs_swap_a: assert property (
      upCnt == 4'hf && $past(bootFromAlt_r, 3) == bootFromAlt_r |-> flash0Cs_n_r ==
         (bootFromAlt_r ? $past(procCs1_n, 3) : $past(procCs0_n, 3)))
      else $error("chip select mismatch");
   abort_pulse_a: assert property (
      abortIrq_r |-> !hardReset_r && $past(panelButton_n, 2) ##1 !abortIrq_r)
      else $error("abort pulse wrong");
   reset_len_a: assert property (
      $fell(hardReset_r) |-> hrCnt == HRST_CYC)
      else $error("hard reset length wrong");
   sys_reset_a: assert property (
      sysReset_r |-> hardReset_r && sysCtrlRole_r)
      else $error("backplane reset without role");
   boot_stop_a: assert property (
      cmdWrite && cmdData == `BWD_CODE_BOOT && bootWdActive_r && !porRequest_r
         |-> ##2 !bootWdActive_r)
      else $error("boot watchdog not stopped");
   os_stop_a: assert property (
      cmdWrite && cmdData == `BWD_CODE_OS && osWdActive_r |-> ##2 !osWdActive_r)
      else $error("os watchdog not stopped");
   alt_keep_a: assert property (
      bootFromAlt_r |=> bootFromAlt_r)
      else $error("boot device switched back");
endmodule
bind bwd_board_ctrl bwd_ctrl_chk #(.HRST_CYC(HRST_CYC)) u_bwd_ctrl_chk (.*);

// ### tb/test_bwd_board_ctrl.sv
// Testbench for the board watchdog, reset and boot control block
`timescale 1ns/1ns
`include "bwd_board_defs.vh"
module test_bwd_board_ctrl;
   localparam [31:0] PRESS_N = 32'd20, BOOT_N = 32'd50, OS_N = 32'd80, PULSE_N = 32'd10;
   reg ref_clk = 1'b0, reset = 1'b1, wdEnableSw = 1'b0, consoleRearSw = 1'b0;
   reg frontDiffSw = 1'b0, fabricPcieSw = 1'b0, portBInvertSw = 1'b0, flashWpSw = 1'b0;
   reg endpointSw = 1'b0, autoRoleSw = 1'b0, manualRoleSel = 1'b0, bootAltSw = 1'b0;
   reg panelButton_n = 1'b1, slotOneDetect = 1'b0, procCs0_n = 1'b0, procCs1_n = 1'b1;
   reg  [3:0]  rearDiffSw = 4'h0;
   reg  [5:0]  geoAddrSw = 6'h00, geoAddrIn = 6'h00;
   wire        cmdWrite, consoleToRear_r, portAPcie_r, portBPcie_r, flashWp_r;
   wire        fabricEndpoint_r, sysCtrlRole_r, flash0Cs_n_r, flash1Cs_n_r, bootFromAlt_r;
   wire        abortIrq_r, hardReset_r, sysReset_r, porRequest_r, bootWdActive_r, osWdActive_r;
   wire [15:0] cmdData;
   wire [4:0]  serialDiff_r;
   wire [5:0]  geoAddrOut_r, geoAddrOe_r, geoAddrSeen_r;
   integer     fails = 0, check_count = 0, abortSeen = 0, rstSeen = 0, n, a, r;
   bwd_board_ctrl #(.PRESS_CYC(PRESS_N), .BOOT_WD_CYC(BOOT_N), .OS_WD_CYC(OS_N),
      .HRST_CYC(PULSE_N)) u_bwd_board_ctrl (.*);
   bwd_host_model u_bwd_host_model (.ref_clk(ref_clk), .cmdWrite(cmdWrite), .cmdData(cmdData));
   always #25 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      abortSeen = abortSeen + (abortIrq_r === 1'b1);
      rstSeen = rstSeen + (porRequest_r === 1'b1 || hardReset_r === 1'b1);
   end
   task check(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task tally_and_finish;
      begin
         if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task cyc(input integer k);
      repeat (k) @(negedge ref_clk);
   endtask
   task apply_reset;
      begin
         reset = 1'b1;
         cyc(16);
         reset = 1'b0;
      end
   endtask
   function pick(input integer w);
      pick = w ? hardReset_r : porRequest_r;
   endfunction
   // Edges until the chosen reset output goes high, or while it stays high
   task wait_lvl(input integer w, input lvl, output integer cnt);
      begin
         cnt = 0;
         while ((pick(w) === lvl) != 1'b1 && cnt < 1000) begin
            cyc(1);
            cnt = cnt + 1;
         end
         if (cnt >= 1000)
            fails = fails + 1;
      end
   endtask
   task t_switches;
      integer i;
      reg [15:0] w;
      for (i = 0; i < 4; i = i + 1) begin
         w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : (i == 2) ? 16'ha5a5 : 16'h5a5a;
         {slotOneDetect, manualRoleSel, autoRoleSw, endpointSw, flashWpSw, portBInvertSw,
            fabricPcieSw, frontDiffSw, rearDiffSw, consoleRearSw} = w[12:0];
         geoAddrSw = w[15:10];
         geoAddrIn = ~w[5:0];
         cyc(4);
         check({consoleToRear_r, serialDiff_r, portAPcie_r, portBPcie_r, flashWp_r,
            fabricEndpoint_r},
            {w[0], w[5:1], w[6], w[6] ^ w[7], w[8], w[9]});
         check(sysCtrlRole_r, w[10] ? !w[11] : w[12]);
         check({geoAddrOut_r, geoAddrOe_r, geoAddrSeen_r}, {6'h00, w[15:10], ~w[5:0]});
      end
   endtask
   task t_wd_off;
      begin
         wdEnableSw = 1'b0;
         apply_reset;
         r = rstSeen;
         cyc(BOOT_N * 2);
         check(rstSeen - r, 0);
      end
   endtask
   task t_boot_fail;
      begin
         wdEnableSw = 1'b1;
         apply_reset;
         cyc(8);
         check({bootFromAlt_r, flash0Cs_n_r, flash1Cs_n_r}, 3'b001);
         wait_lvl(0, 1'b1, n);
         // Enable switch sync and output flop add three edges
         check(n + 8, BOOT_N + 3);
         wait_lvl(0, 1'b0, n);
         check(n, PULSE_N);
         cyc(8);
         check({bootFromAlt_r, flash0Cs_n_r, flash1Cs_n_r}, 3'b110);
         wait_lvl(0, 1'b1, n);
         wait_lvl(0, 1'b0, n);
         cyc(8);
         check({bootFromAlt_r, flash0Cs_n_r, flash1Cs_n_r}, 3'b110);
      end
   endtask
   task t_os_expire;
      begin
         slotOneDetect = 1'b1;
         autoRoleSw = 1'b0;
         apply_reset;
         cyc(4);
         u_bwd_host_model.send(16'h1234);
         cyc(2);
         check({bootWdActive_r, osWdActive_r}, 2'b10);
         u_bwd_host_model.send(`BWD_CODE_BOOT);
         cyc(2);
         check({bootWdActive_r, osWdActive_r}, 2'b01);
         r = rstSeen;
         wait_lvl(1, 1'b1, n);
         check(n >= OS_N - 2 && n <= OS_N + 3 && porRequest_r === 1'b0, 1);
         check(sysReset_r, 1'b1);
         wait_lvl(1, 1'b0, n);
         check(n, PULSE_N);
      end
   endtask
   task t_os_service;
      begin
         bootAltSw = 1'b1;
         apply_reset;
         cyc(4);
         u_bwd_host_model.send(`BWD_CODE_BOOT);
         u_bwd_host_model.send(`BWD_CODE_OS);
         cyc(2);
         check({bootWdActive_r, osWdActive_r}, 2'b00);
         check({bootFromAlt_r, flash0Cs_n_r, flash1Cs_n_r}, 3'b110);
         r = rstSeen;
         cyc(OS_N + 20);
         check(rstSeen - r, 0);
      end
   endtask
   task t_button;
      begin
         wdEnableSw = 1'b0;
         slotOneDetect = 1'b0;
         apply_reset;
         cyc(4);
         a = abortSeen;
         r = rstSeen;
         panelButton_n = 1'b0;
         cyc(PRESS_N - 5);
         panelButton_n = 1'b1;
         cyc(8);
         check(abortSeen - a, 1);
         check(rstSeen - r, 0);
         panelButton_n = 1'b0;
         wait_lvl(1, 1'b1, n);
         check(n > PRESS_N && n <= PRESS_N + 7, 1);
         check(sysReset_r, 1'b0);
         wait_lvl(1, 1'b0, n);
         panelButton_n = 1'b1;
         cyc(8);
         check(abortSeen - a, 1);
      end
   endtask
   initial begin
      #500000;
      fails = fails + 1;
      tally_and_finish;
   end
   initial begin
      apply_reset;
      t_switches;
      t_wd_off;
      t_boot_fail;
      t_os_expire;
      t_os_service;
      t_button;
      tally_and_finish;
   end
endmodule
